/* hdl/dtcc_top.sv */
// Dual time-base capture/compare unit with sixteen channels.
`timescale 1ns/1ps

module dtcc_top
  import dtcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Time-base control
  input wire dtcc_tb_cfg_t [NUM_TB-1:0] tb_cfg,
  input wire logic [NUM_TB-1:0][TMR_W-1:0] tb_reload,
  input wire logic [NUM_TB-1:0] tb_load,
  input wire logic [NUM_TB-1:0][TMR_W-1:0] tb_load_val,
  input wire logic stagger_en,
  // Count sources
  input wire logic aux_timer_six_ovf,
  input wire logic [NUM_TB-1:0] ext_cnt_in,
  // Channel control
  input wire dtcc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
  input wire logic [NUM_CH-1:0] ch_wr,
  input wire logic [TMR_W-1:0] ch_wr_val,
  input wire logic [NUM_CH-1:0] ch_rearm,
  // Channel pins
  input wire logic [NUM_CH-1:0] ch_pin_in,
  output logic [NUM_CH-1:0] ch_pin_out,
  output logic [NUM_CH-1:0] ch_pin_oe,
  // Status
  output logic [NUM_CH-1:0][TMR_W-1:0] ch_value,
  output logic [NUM_CH-1:0] ch_irq,
  output logic [NUM_CH-1:0] ch_halted,
  output logic [NUM_TB-1:0][TMR_W-1:0] tb_count,
  output logic [NUM_TB-1:0] tb_ovf
);

  //////////////////////////////////////////////////////////////////////////////

  logic [STAG_W-1:0] stag_cnt_r;
  logic [PRESC_W-1:0] presc_cnt_r;
  logic slot_ok;
  logic [NUM_TB-1:0] ext_prev_r;
  logic [NUM_TB-1:0] ev_pend_r;
  logic [NUM_TB-1:0] ev_now;
  logic [NUM_TB-1:0] tick_w;
  logic [NUM_CH-1:0] pin_prev_r;
  dtcc_tb_stat_t [NUM_TB-1:0] tb_stat;
  dtcc_act_t [NUM_CH-1:0] act;

  // In staggered operation the timers move only in one slot of eight.
  assign slot_ok = !stagger_en || stag_cnt_r == STAG_SLOT;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stag_cnt_r <= STAG_SLOT;
    else if (clk_en)
      stag_cnt_r <= stag_cnt_r + STAG_STEP;
  end

  // The prescaler advances only in usable slots so no division is skipped.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      presc_cnt_r <= '0;
    else if (clk_en && slot_ok)
      presc_cnt_r <= presc_cnt_r + PRESC_STEP;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_prev_r <= '0;
      pin_prev_r <= '0;
    end
    else if (clk_en)
    begin
      ext_prev_r <= ext_cnt_in;
      pin_prev_r <= ch_pin_in;
    end
  end

  // Count events seen outside the slot are held until the next slot.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ev_pend_r <= '0;
    else if (clk_en)
    begin
      if (slot_ok)
        ev_pend_r <= '0;
      else
        ev_pend_r <= ev_pend_r | ev_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  for (genvar t = 0; t < NUM_TB; t++)
  begin : g_tb
    logic [PRESC_W-1:0] mask;
    logic presc_hit;
    logic ext_edge;

    assign mask = PRESC_W'((1 << tb_cfg[t].psel) - 1);
    assign presc_hit = (presc_cnt_r & mask) == mask;
    assign ext_edge = ext_cnt_in[t] & ~ext_prev_r[t];
    assign ev_now[t] =
      (tb_cfg[t].src == TB_SRC_AUX && aux_timer_six_ovf) ||
      (tb_cfg[t].src == TB_SRC_EXT && ext_edge);
    assign tick_w[t] = tb_cfg[t].run && slot_ok &&
      ((tb_cfg[t].src == TB_SRC_PRESC && presc_hit) ||
       ev_pend_r[t] || ev_now[t]);

    dtcc_timebase i_dtcc_timebase (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tick(tick_w[t]),
      .reload(tb_reload[t]),
      .load(tb_load[t]),
      .load_val(tb_load_val[t]),
      .count_r(tb_stat[t].count),
      .upd_r(tb_stat[t].upd),
      .ovf_r(tb_stat[t].ovf)
    );

    assign tb_count[t] = tb_stat[t].count;
    assign tb_ovf[t] = tb_stat[t].ovf;

    property p_presc_half;
      @(posedge clk) disable iff (sys_rst)
        clk_en && !stagger_en && tb_cfg[t].src == TB_SRC_PRESC &&
        tb_cfg[t].psel != '0 && tick_w[t]
        |=> !tick_w[t];
    endproperty
    a_presc_half: assert property (p_presc_half)
      else $error("prescaled tick came on two cycles in a row");

    property p_aux_count;
      @(posedge clk) disable iff (sys_rst)
        clk_en && !stagger_en && !tb_load[t] && tb_cfg[t].run &&
        tb_cfg[t].src == TB_SRC_AUX && aux_timer_six_ovf
        |=> tb_stat[t].upd;
    endproperty
    a_aux_count: assert property (p_aux_count)
      else $error("aux timer overflow did not advance the timer");

    property p_ext_count;
      @(posedge clk) disable iff (sys_rst)
        clk_en && !stagger_en && !tb_load[t] && tb_cfg[t].run &&
        tb_cfg[t].src == TB_SRC_EXT && ext_cnt_in[t] && !ext_prev_r[t]
        |=> tb_stat[t].upd;
    endproperty
    a_ext_count: assert property (p_ext_count)
      else $error("external count edge did not advance the timer");

    property p_stagger;
      @(posedge clk) disable iff (sys_rst)
        stagger_en && clk_en && tick_w[t]
        |=> (!tick_w[t] || !stagger_en)[*7];
    endproperty
    a_stagger: assert property (p_stagger)
      else $error("staggered timer moved twice within eight cycles");
  end

  //////////////////////////////////////////////////////////////////////////////

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    logic own_tog;
    logic partner_tog;
    logic drive;
    logic pin_q;
    logic oe_q;

    dtcc_channel i_dtcc_channel (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .cfg(ch_cfg[i]),
      .wr(ch_wr[i]),
      .wr_val(ch_wr_val),
      .rearm(ch_rearm[i]),
      .tb(tb_stat),
      .pin_in(ch_pin_in[i]),
      .pin_prev(pin_prev_r[i]),
      .value_r(ch_value[i]),
      .irq_r(ch_irq[i]),
      .halted_r(ch_halted[i]),
      .act_r(act[i])
    );

    // The lower channel of a pair owns the shared pin in double mode.
    if (i < PAIR_OFS)
    begin : g_lo
      assign partner_tog = act[i+PAIR_OFS].tog &&
        ch_cfg[i+PAIR_OFS].mode == CH_DOUBLE;
      assign own_tog = act[i].tog;
      assign drive = ch_cfg[i].mode inside {CH_CMP1, CH_CMP3, CH_DOUBLE} ||
        ch_cfg[i+PAIR_OFS].mode == CH_DOUBLE;
    end
    else
    begin : g_hi
      assign partner_tog = 1'b0;
      assign own_tog = act[i].tog && ch_cfg[i].mode != CH_DOUBLE;
      assign drive = ch_cfg[i].mode inside {CH_CMP1, CH_CMP3};

      property p_double_hi_quiet;
        @(posedge clk) disable iff (sys_rst)
          clk_en && ch_cfg[i].mode == CH_DOUBLE && !act[i].set &&
          !act[i].clr |=> $stable(ch_pin_out[i]);
      endproperty
      a_double_hi_quiet: assert property (p_double_hi_quiet)
        else $error("upper double channel moved its own pin");
    end

    // A set wins over an overflow clear that lands in the same cycle.
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        pin_q <= 1'b0;
      else if (clk_en)
      begin
        if (act[i].set)
          pin_q <= 1'b1;
        else if (act[i].clr)
          pin_q <= 1'b0;
        else if (own_tog ^ partner_tog)
          pin_q <= ~pin_q;
      end
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        oe_q <= 1'b0;
      else if (clk_en)
        oe_q <= drive;
    end

    assign ch_pin_out[i] = pin_q;
    assign ch_pin_oe[i] = oe_q;

    property p_toggle;
      @(posedge clk) disable iff (sys_rst)
        clk_en && !act[i].set && !act[i].clr && (own_tog ^ partner_tog)
        |=> ch_pin_out[i] == !$past(ch_pin_out[i]);
    endproperty
    a_toggle: assert property (p_toggle)
      else $error("compare match did not toggle the pin");

    property p_mode3;
      @(posedge clk) disable iff (sys_rst)
        clk_en && act[i].set |=> ch_pin_out[i];
    endproperty
    a_mode3: assert property (p_mode3)
      else $error("mode 3 match did not set the pin");

    property p_mode3_clr;
      @(posedge clk) disable iff (sys_rst)
        clk_en && act[i].clr && !act[i].set |=> !ch_pin_out[i];
    endproperty
    a_mode3_clr: assert property (p_mode3_clr)
      else $error("overflow did not clear the mode 3 pin");

    property p_mode0_quiet;
      @(posedge clk) disable iff (sys_rst)
        clk_en && ch_cfg[i].mode == CH_CMP0 && !partner_tog
        |=> $stable(ch_pin_out[i]);
    endproperty
    a_mode0_quiet: assert property (p_mode0_quiet)
      else $error("mode 0 channel moved its pin");

    property p_oe_drive;
      @(posedge clk) disable iff (sys_rst)
        clk_en && ch_cfg[i].mode inside {CH_CMP1, CH_CMP3}
        |=> ch_pin_oe[i];
    endproperty
    a_oe_drive: assert property (p_oe_drive)
      else $error("compare channel did not drive its pin");
  end

endmodule : dtcc_top

/* pkg/dtcc_pkg.sv */
// Shared constants and types of the dual time-base capture/compare unit.
package dtcc_pkg;

  localparam int NUM_CH = 16;
  localparam int NUM_TB = 2;
  localparam int TMR_W = 16;
  // Partner distance of the two channels that share a pin in double mode.
  localparam int PAIR_OFS = 8;
  // Staggered operation gives one timer slot in every eight cycles.
  localparam int STAG_W = 3;
  localparam logic [STAG_W-1:0] STAG_SLOT = 3'h0;
  localparam logic [STAG_W-1:0] STAG_STEP = 3'h1;
  localparam int PRESC_W = 8;
  localparam int PSEL_W = 3;
  localparam logic [PRESC_W-1:0] PRESC_STEP = 8'h01;
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

  typedef enum logic [1:0] {
    TB_SRC_PRESC = 2'b00,
    TB_SRC_AUX = 2'b01,
    TB_SRC_EXT = 2'b10,
    TB_SRC_STOP = 2'b11
  } dtcc_src_t;

  typedef enum logic [2:0] {
    CH_OFF = 3'b000,
    CH_CAPTURE = 3'b001,
    CH_CMP0 = 3'b010,
    CH_CMP1 = 3'b011,
    CH_CMP2 = 3'b100,
    CH_CMP3 = 3'b101,
    CH_DOUBLE = 3'b110
  } dtcc_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } dtcc_edge_t;

  typedef struct packed {
    logic run;
    dtcc_src_t src;
    logic [PSEL_W-1:0] psel;
  } dtcc_tb_cfg_t;

  typedef struct packed {
    dtcc_mode_t mode;
    dtcc_edge_t edge_sel;
    logic tsel;
    logic single;
  } dtcc_ch_cfg_t;

  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic upd;
    logic ovf;
  } dtcc_tb_stat_t;

  typedef struct packed {
    logic tog;
    logic set;
    logic clr;
  } dtcc_act_t;

endpackage : dtcc_pkg

/* hdl/dtcc_timebase.sv */
// One reloadable 16-bit up-counting time base.
`timescale 1ns/1ps
module dtcc_timebase
  import dtcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Count control
  input wire logic tick,
  input wire logic [TMR_W-1:0] reload,
  input wire logic load,
  input wire logic [TMR_W-1:0] load_val,
  // State
  output logic [TMR_W-1:0] count_r,
  output logic upd_r,
  output logic ovf_r
);

  localparam logic [TMR_W-1:0] TOP = {TMR_W{1'b1}};
  localparam logic [TMR_W-1:0] ONE = TMR_W'(1);

  // A software load takes priority over a count in the same cycle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_r <= TMR_RST;
      upd_r <= 1'b0;
      ovf_r <= 1'b0;
    end
    else if (clk_en)
    begin
      upd_r <= load | tick;
      ovf_r <= !load && tick && count_r == TOP;
      if (load)
        count_r <= load_val;
      else if (tick && count_r == TOP)
        count_r <= reload;
      else if (tick)
        count_r <= count_r + ONE;
    end
  end

  property p_tb_reload;
    @(posedge clk) disable iff (sys_rst)
      clk_en && tick && !load && count_r == TOP
      |=> count_r == $past(reload) && ovf_r && upd_r;
  endproperty
  a_tb_reload: assert property (p_tb_reload)
    else $error("time base did not reload on overflow");

  property p_tb_step;
    @(posedge clk) disable iff (sys_rst)
      clk_en && tick && !load && count_r != TOP
      |=> count_r == $past(count_r) + ONE && !ovf_r;
  endproperty
  a_tb_step: assert property (p_tb_step)
    else $error("time base did not advance by one");

endmodule : dtcc_timebase

/* hdl/dtcc_channel.sv */
// One capture/compare channel register with its mode logic.
`timescale 1ns/1ps
module dtcc_channel
  import dtcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration
  input wire dtcc_ch_cfg_t cfg,
  input wire logic wr,
  input wire logic [TMR_W-1:0] wr_val,
  input wire logic rearm,
  // Time bases
  input wire dtcc_tb_stat_t [NUM_TB-1:0] tb,
  // Pin sample
  input wire logic pin_in,
  input wire logic pin_prev,
  // Results
  output logic [TMR_W-1:0] value_r,
  output logic irq_r,
  output logic halted_r,
  output dtcc_act_t act_r
);

  logic [TMR_W-1:0] tval;
  logic tupd;
  logic tovf;
  logic rise;
  logic fall;
  logic cap_hit;
  logic is_cmp;
  logic once;
  logic match;
  logic fire;
  logic end_pulse;
  logic done_r;

  assign tval = tb[cfg.tsel].count;
  assign tupd = tb[cfg.tsel].upd;
  assign tovf = tb[cfg.tsel].ovf;
  assign rise = pin_in & ~pin_prev;
  assign fall = ~pin_in & pin_prev;
  assign cap_hit = cfg.mode == CH_CAPTURE &&
    ((rise && (cfg.edge_sel == EDGE_RISE || cfg.edge_sel == EDGE_BOTH)) ||
     (fall && (cfg.edge_sel == EDGE_FALL || cfg.edge_sel == EDGE_BOTH)));
  assign is_cmp = cfg.mode inside {CH_CMP0, CH_CMP1, CH_CMP2, CH_CMP3,
    CH_DOUBLE};
  assign once = cfg.mode == CH_CMP2 || cfg.mode == CH_CMP3;
  // A match counts only when the timer has just taken a new value.
  assign match = is_cmp && tupd && tval == value_r && !halted_r;
  assign fire = match && !(once && done_r);
  assign end_pulse = cfg.mode == CH_CMP3 && tovf;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      value_r <= TMR_RST;
    else if (clk_en)
    begin
      if (cap_hit)
        value_r <= tval;
      else if (wr)
        value_r <= wr_val;
    end
  end

  // Once-per-period flag; a match in the overflow cycle sets it only if the old period left it clear.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      done_r <= 1'b0;
    else if (clk_en)
    begin
      if (fire && once)
        done_r <= 1'b1;
      else if (tovf)
        done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      halted_r <= 1'b0;
    else if (clk_en)
    begin
      if (cfg.single && ((fire && cfg.mode != CH_CMP3) ||
          (end_pulse && done_r)))
        halted_r <= 1'b1;
      else if (rearm)
        halted_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_r <= 1'b0;
      act_r <= '0;
    end
    else if (clk_en)
    begin
      irq_r <= cap_hit || (fire && cfg.mode != CH_DOUBLE);
      act_r.tog <= fire && (cfg.mode == CH_CMP1 || cfg.mode == CH_DOUBLE);
      act_r.set <= fire && cfg.mode == CH_CMP3;
      act_r.clr <= end_pulse;
    end
  end

  property p_capture;
    @(posedge clk) disable iff (sys_rst)
      clk_en && cap_hit |=> value_r == $past(tval) && irq_r;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not latch the timer value");

  property p_edge_rise_only;
    @(posedge clk) disable iff (sys_rst)
      clk_en && cfg.mode == CH_CAPTURE && cfg.edge_sel == EDGE_RISE && fall
      |=> !irq_r;
  endproperty
  a_edge_rise_only: assert property (p_edge_rise_only)
    else $error("falling edge captured in rising-only mode");

  property p_once_per_period;
    @(posedge clk) disable iff (sys_rst)
      clk_en && cfg.mode == CH_CMP2 && done_r && match |=> !irq_r;
  endproperty
  a_once_per_period: assert property (p_once_per_period)
    else $error("second interrupt in one period");

  property p_halted_quiet;
    @(posedge clk) disable iff (sys_rst)
      clk_en && halted_r && !rearm && is_cmp |=> halted_r && !irq_r;
  endproperty
  a_halted_quiet: assert property (p_halted_quiet)
    else $error("halted channel still acted");

endmodule : dtcc_channel

/* dv/dtcc_pin_model.sv */
// Behavioural model of the channel port pins outside the unit.
`timescale 1ns/1ps
module dtcc_pin_model
  import dtcc_pkg::*;
(
  // Unit side of the pins
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  // Levels the outside world puts on undriven pins
  input wire logic [NUM_CH-1:0] drv,
  // Resolved pin levels fed back to the unit
  output logic [NUM_CH-1:0] pin_level
);
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : drv[i];
    end
  end
endmodule : dtcc_pin_model

/* dv/dtcc_top_tb_top.sv */
// Self-checking testbench of the dual time-base capture/compare unit.
`timescale 1ns/1ps
module dtcc_top_tb_top
  import dtcc_pkg::*;
;
  logic clk, sys_rst, clk_en, stagger_en, aux_timer_six_ovf;
  dtcc_tb_cfg_t [NUM_TB-1:0] tb_cfg;
  logic [NUM_TB-1:0][TMR_W-1:0] tb_reload, tb_load_val, tb_count;
  logic [NUM_TB-1:0] tb_load, ext_cnt_in, tb_ovf;
  dtcc_ch_cfg_t [NUM_CH-1:0] ch_cfg;
  logic [NUM_CH-1:0] ch_wr, ch_rearm, ch_pin_in, ch_pin_out, ch_pin_oe;
  logic [NUM_CH-1:0] ch_irq, ch_halted, pin_drv;
  logic [NUM_CH-1:0][TMR_W-1:0] ch_value;
  logic [TMR_W-1:0] ch_wr_val, v, c0;
  logic [19:0] exp_q[$];
  logic [19:0] e;
  int errors, checks, seed;

  dtcc_top i_dtcc_top (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .tb_cfg(tb_cfg), .tb_reload(tb_reload), .tb_load(tb_load),
    .tb_load_val(tb_load_val), .stagger_en(stagger_en),
    .aux_timer_six_ovf(aux_timer_six_ovf), .ext_cnt_in(ext_cnt_in),
    .ch_cfg(ch_cfg), .ch_wr(ch_wr), .ch_wr_val(ch_wr_val),
    .ch_rearm(ch_rearm), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
    .ch_pin_oe(ch_pin_oe), .ch_value(ch_value), .ch_irq(ch_irq),
    .ch_halted(ch_halted), .tb_count(tb_count), .tb_ovf(tb_ovf));

  dtcc_pin_model i_dtcc_pin_model (.pin_out(ch_pin_out), .pin_oe(ch_pin_oe),
    .drv(pin_drv), .pin_level(ch_pin_in));

  ////////////////////////////////////////////////////////////////////////
  function automatic dtcc_ch_cfg_t chc(dtcc_mode_t m, logic s);
    chc = '{mode: m, edge_sel: EDGE_NONE, tsel: 1'b0, single: s};
  endfunction : chc

  function automatic dtcc_tb_cfg_t tbc(logic r, dtcc_src_t s, logic [2:0] p);
    tbc = '{run: r, src: s, psel: p};
  endfunction : tbc

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic clk_n(int n);
    repeat (n) @(posedge clk);
  endtask : clk_n

  task automatic tb_ld(int t, logic [15:0] val);
    @(posedge clk);
    tb_load[t] <= 1'b1;
    tb_load_val[t] <= val;
    @(posedge clk);
    tb_load[t] <= 1'b0;
  endtask : tb_ld

  task automatic wr_ch(int c, dtcc_ch_cfg_t cf, logic [15:0] val);
    @(posedge clk);
    ch_cfg[c] <= cf;
    ch_wr[c] <= 1'b1;
    ch_wr_val <= val;
    @(posedge clk);
    ch_wr[c] <= 1'b0;
  endtask : wr_ch

  // Waits for an overflow or for a given count, with a bounded wait.
  task automatic wait_tb(int t, logic [15:0] val, bit ovf);
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk);
      #1;
      if (ovf ? tb_ovf[t] === 1'b1 : tb_count[t] === val)
        return;
    end
    chk("wait_tb", 16'h0001, 16'h0000);
  endtask : wait_tb

  // Runs a time base from zero for n cycles and checks the count reached.
  task automatic span(int t, dtcc_tb_cfg_t cf, int n, int exp, string name);
    tb_ld(t, 16'h0000);
    @(posedge clk);
    tb_cfg[t] <= cf;
    clk_n(n);
    tb_cfg[t] <= tbc(1'b0, cf.src, cf.psel);
    clk_n(3);
    #1;
    if (tb_count[t] >= exp - 1 && tb_count[t] <= exp + 1)
      chk(name, 16'(exp), 16'(exp));
    else
      chk(name, 16'(exp), tb_count[t]);
  endtask : span

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #200000;
    errors++;
    results();
  end

  // Each interrupt pulse takes the oldest expected channel and value.
  always @(posedge clk)
  begin
    if (!sys_rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (ch_irq[i] === 1'b1)
        begin
          if (exp_q.size() == 0)
            chk("irq_extra", 16'h0000, 16'h0001);
          else
          begin
            e = exp_q.pop_front();
            chk("irq_ch", 16'(e[19:16]), 16'(i));
            chk("ch_value", e[15:0], ch_value[i]);
          end
        end
      end
    end
  end

  initial
  begin
    seed = 47443;
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    stagger_en = 1'b0;
    aux_timer_six_ovf = 1'b0;
    tb_cfg = '0;
    tb_reload = '0;
    tb_load = '0;
    tb_load_val = '0;
    ext_cnt_in = '0;
    ch_cfg = '0;
    ch_wr = '0;
    ch_wr_val = '0;
    ch_rearm = '0;
    pin_drv = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("oe_rst", 16'h0000, ch_pin_oe);
    chk("cnt_rst", 16'h0000, tb_count[0]);
    // Overflow reload and clock enable freeze.
    v = 16'($random(seed));
    @(posedge clk);
    tb_reload[0] <= v;
    tb_ld(0, 16'hfff0);
    @(posedge clk);
    tb_cfg[0] <= tbc(1'b1, TB_SRC_PRESC, 3'h0);
    wait_tb(0, 16'h0000, 1'b1);
    chk("tb0_reload", v, tb_count[0]);
    @(posedge clk);
    #1;
    chk("tb0_ovf_len", 16'h0000, 16'(tb_ovf[0]));
    chk("tb0_next", v + 16'h0001, tb_count[0]);
    @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    #1;
    c0 = tb_count[0];
    clk_n(10);
    #1;
    chk("tb0_frozen", c0, tb_count[0]);
    @(posedge clk);
    clk_en <= 1'b1;
    tb_cfg[0] <= tbc(1'b0, TB_SRC_PRESC, 3'h0);
    // Count sources and staggered resolution.
    span(1, tbc(1'b1, TB_SRC_PRESC, 3'h2), 400, 100, "tb1_presc");
    @(posedge clk);
    stagger_en <= 1'b1;
    span(1, tbc(1'b1, TB_SRC_PRESC, 3'h0), 400, 50, "tb1_stag");
    @(posedge clk);
    stagger_en <= 1'b0;
    tb_ld(1, 16'h0000);
    @(posedge clk);
    tb_cfg[1] <= tbc(1'b1, TB_SRC_AUX, 3'h0);
    repeat (7)
    begin
      @(posedge clk);
      aux_timer_six_ovf <= 1'b1;
      @(posedge clk);
      aux_timer_six_ovf <= 1'b0;
      clk_n(2);
    end
    @(posedge clk);
    tb_cfg[1] <= tbc(1'b1, TB_SRC_EXT, 3'h0);
    repeat (5)
    begin
      @(posedge clk);
      ext_cnt_in[1] <= 1'b1;
      clk_n(2);
      ext_cnt_in[1] <= 1'b0;
      clk_n(2);
    end
    clk_n(3);
    tb_cfg[1] <= tbc(1'b0, TB_SRC_EXT, 3'h0);
    clk_n(2);
    #1;
    chk("tb1_aux_ext", 16'h000c, tb_count[1]);
    // Capture on the rise, fall and both edge selections, timer one held at a random value.
    for (int g = 1; g < 4; g++)
    begin
      v = 16'($random(seed));
      tb_ld(1, v);
      @(posedge clk);
      ch_cfg[0] <= '{mode: CH_CAPTURE, edge_sel: dtcc_edge_t'(g),
                     tsel: 1'b1, single: 1'b0};
      clk_n(3);
      if (g != 2)
        exp_q.push_back({4'h0, v});
      pin_drv[0] <= 1'b1;
      clk_n(4);
      if (g != 1)
        exp_q.push_back({4'h0, v});
      pin_drv[0] <= 1'b0;
      clk_n(4);
    end
    // Compare modes on timer zero with a 256-cycle period.
    @(posedge clk);
    ch_cfg[0] <= chc(CH_OFF, 1'b0);
    tb_reload[0] <= 16'hff00;
    tb_ld(0, 16'hff00);
    wr_ch(1, chc(CH_CMP0, 1'b0), 16'hff80);
    wr_ch(3, chc(CH_CMP2, 1'b0), 16'hff80);
    wr_ch(4, chc(CH_CMP1, 1'b0), 16'hff80);
    wr_ch(5, chc(CH_CMP3, 1'b0), 16'hff80);
    wr_ch(7, chc(CH_CMP1, 1'b1), 16'hff80);
    wr_ch(6, chc(CH_DOUBLE, 1'b0), 16'hff40);
    wr_ch(14, chc(CH_DOUBLE, 1'b0), 16'hffc0);
    for (int c = 0; c < NUM_CH; c++)
      if (c inside {1, 3, 4, 5, 7})
        exp_q.push_back({4'(c), 16'hff80});
    for (int c = 0; c < NUM_CH; c++)
      if (c inside {1, 3, 4, 5})
        exp_q.push_back({4'(c), 16'hff80});
    @(posedge clk);
    tb_cfg[0] <= tbc(1'b1, TB_SRC_PRESC, 3'h0);
    wait_tb(0, 16'h0000, 1'b1);
    clk_n(4);
    #1;
    chk("pin4_p1", 16'h0001, 16'(ch_pin_out[4]));
    chk("oe4", 16'h0001, 16'(ch_pin_oe[4]));
    chk("pin5_ovf", 16'h0000, 16'(ch_pin_out[5]));
    chk("pin7_p1", 16'h0001, 16'(ch_pin_out[7]));
    chk("halt7", 16'h0001, 16'(ch_halted[7]));
    wait_tb(0, 16'hffa0, 1'b0);
    chk("pin4_p2", 16'h0000, 16'(ch_pin_out[4]));
    chk("pin5_p2", 16'h0001, 16'(ch_pin_out[5]));
    chk("pin6_on", 16'h0001, 16'(ch_pin_out[6]));
    chk("pin7_p2", 16'h0001, 16'(ch_pin_out[7]));
    wait_tb(0, 16'hffd0, 1'b0);
    chk("pin6_off", 16'h0000, 16'(ch_pin_out[6]));
    @(posedge clk);
    tb_cfg[0] <= tbc(1'b0, TB_SRC_PRESC, 3'h0);
    ch_rearm[7] <= 1'b1;
    @(posedge clk);
    ch_rearm[7] <= 1'b0;
    clk_n(2);
    #1;
    chk("halt7_rearm", 16'h0000, 16'(ch_halted[7]));
    clk_n(5);
    chk("irq_left", 16'h0000, 16'(exp_q.size()));
    results();
  end
endmodule : dtcc_top_tb_top
